// ==== inc/bspl_pkg.sv ====
// Purpose: shared constants and types for the banked stack pointer and limit register slice
// Assumes: 32-bit core, core register numbering 0..15 plus special register selectors
// Notes: special register selector codes are local to this slice
package bspl_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned GPR_COUNT = 13;
  localparam int unsigned LIMIT_LSB = 3;
  localparam logic [31:0] LIMIT_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] LINK_RESET_NOSEC = 32'hFFFF_FFFF;
  localparam int unsigned THUMB_BIT = 24;
  localparam int unsigned EXC_NUM_W = 9;
  localparam logic [31:0] APP_FLAGS_MASK = 32'hF80F_0000;
  localparam logic [31:0] EXEC_STATE_MASK = 32'h0700_FC00;
  localparam logic [31:0] EXC_NUM_MASK = 32'h0000_01FF;
  localparam logic [31:0] PUSH_STEP = 32'h0000_0004;

  // register selectors on the access port
  typedef enum logic [4:0] {
    BSPL_SEL_GPR0 = 5'h00,
    BSPL_SEL_SP = 5'h0D,
    BSPL_SEL_LINK = 5'h0E,
    BSPL_SEL_PC = 5'h0F,
    BSPL_SEL_STATUS = 5'h10,
    BSPL_SEL_SECURE_MAIN_STACK_POINTER = 5'h11,
    BSPL_SEL_SECURE_PROCESS_STACK_POINTER = 5'h12,
    BSPL_SEL_NONSECURE_MAIN_STACK_POINTER = 5'h13,
    BSPL_SEL_NONSECURE_PROCESS_STACK_POINTER = 5'h14,
    BSPL_SEL_MLIM_S = 5'h15,
    BSPL_SEL_PLIM_S = 5'h16,
    BSPL_SEL_MLIM_NS = 5'h17,
    BSPL_SEL_PLIM_NS = 5'h18
  } bspl_sel_t;

  // index of the four banked stacks: {nonsecure, process}
  localparam logic [1:0] STK_MAIN_S = 2'h0;
  localparam logic [1:0] STK_PROC_S = 2'h1;
  localparam logic [1:0] STK_MAIN_NS = 2'h2;
  localparam logic [1:0] STK_PROC_NS = 2'h3;

  typedef enum logic [1:0] {
    BSPL_RST_IDLE,
    BSPL_RST_RUN
  } bspl_rst_state_t;
endpackage : bspl_pkg

// ==== logic/bspl_limit_check.sv ====
// Purpose: compare a candidate stack pointer against an 8-byte aligned lower limit
// Assumes: limit low bits already cleared or ignored here
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module bspl_limit_check #(
  parameter int unsigned W = 32,
  parameter int unsigned LSB = 3
) (
  // candidate and limit
  input wire logic [W-1:0] i_candidate,
  input wire logic [W-1:0] i_limit,
  // verdict
  output logic o_below
);
  logic [W-1:0] aligned_limit;
  always_comb begin
    aligned_limit = {i_limit[W-1:LSB], {LSB{1'b0}}};
    o_below = (i_candidate < aligned_limit);
  end
endmodule : bspl_limit_check
`default_nettype wire

// ==== logic/bspl_regs.sv ====
// Purpose: general-purpose registers, banked stack pointers and banked stack limits of the core
// Assumes: pipeline issues at most one write, one push/sp update per cycle
// Notes: read port is combinational-free; read data is registered one cycle after the request
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - thirteen 32-bit data registers, no reset value, open to either privilege
// - push decrements active pointer first, so it addresses the last item
// - four stack pointers; security state picks the usable pair
// - thread mode: stack-select set picks process stack, clear main; main after reset
// - handler mode always uses the main pointer of the current state
// - flag an exception when an update goes below the stack limit
// - without security extension only main and process limits exist
// - with security extension four banked limit registers exist
// - limit holds bits 31..3; bits 2..0 read zero
// - reset loads status bit 24 from reset vector bit 0, others clear
// - reset loads main pointer and program counter from fetched vector values
// - unprivileged may reach data, pointers, link, pc, app flags only; code refuses only the limits, status reads show the exception number
// - execution state field read-only; writes ignored, application reads zero
module bspl_regs #(
  parameter bit SECURE_EXT = 1'b1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // reset vector values from the reset sequence
  input wire logic i_vec_load,
  input wire logic [31:0] i_vec_sp,
  input wire logic [31:0] i_vec_pc,
  // execution context
  input wire logic i_handler_mode,
  input wire logic i_secure,
  input wire logic i_privileged,
  input wire logic i_stack_select_bit_s,
  input wire logic i_stack_select_bit_ns,
  // register access port
  input wire logic i_wr_en,
  input wire logic [4:0] i_wr_sel,
  input wire logic [31:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [4:0] i_rd_sel,
  // active stack pointer update
  input wire logic i_sp_upd,
  input wire logic [31:0] i_sp_value,
  input wire logic i_push,
  // program counter and status updates
  input wire logic i_pc_upd,
  input wire logic [31:0] i_pc_value,
  input wire logic [bspl_pkg::EXC_NUM_W-1:0] i_exc_num,
  // outputs
  output logic [31:0] o_rd_data,
  output logic o_rd_denied,
  output logic o_wr_denied,
  output logic [31:0] o_active_sp,
  output logic [31:0] o_push_addr,
  output logic o_limit_violation,
  output logic [31:0] o_program_counter,
  output logic [31:0] o_combined_status_word
);
  import bspl_pkg::*;

  logic [31:0] gpr_reg [GPR_COUNT];
  logic [31:0] sp_reg [4];
  logic [31:0] lim_reg [4];
  logic [31:0] link_register_reg;
  logic [31:0] program_counter_reg;
  logic [31:0] status_reg;
  logic [1:0] act_idx;
  logic [31:0] cand;
  logic below;
  logic wr_ok;
  logic sp_move;

  // privileged-only selectors: the four stack limit registers
  function automatic logic needs_priv(input logic [4:0] sel);
    needs_priv = (sel >= BSPL_SEL_MLIM_S) && (sel <= BSPL_SEL_PLIM_NS);
  endfunction : needs_priv

  // a selector naming a bank that does not exist without the extension
  function automatic logic sel_absent(input logic [4:0] sel);
    sel_absent = !SECURE_EXT && (sel == BSPL_SEL_NONSECURE_MAIN_STACK_POINTER || sel == BSPL_SEL_NONSECURE_PROCESS_STACK_POINTER ||
                 sel == BSPL_SEL_MLIM_NS || sel == BSPL_SEL_PLIM_NS);
  endfunction : sel_absent

  always_comb begin
    // without the extension everything lives in the secure-numbered bank
    act_idx[1] = SECURE_EXT && !i_secure;
    if (i_handler_mode) begin
      act_idx[0] = 1'b0;
    end else begin
      act_idx[0] = act_idx[1] ? i_stack_select_bit_ns : i_stack_select_bit_s;
    end
    cand = i_push ? (sp_reg[act_idx] - PUSH_STEP) : i_sp_value;
    sp_move = i_sp_upd || i_push;
    wr_ok = i_wr_en && (i_privileged || !needs_priv(i_wr_sel)) && !sel_absent(i_wr_sel);
  end

  bspl_limit_check #(
    .W(DATA_W),
    .LSB(LIMIT_LSB)
  ) u_check (
    .i_candidate(cand),
    .i_limit(lim_reg[act_idx]),
    .o_below(below)
  );

  // data registers keep no reset value
  always_ff @(posedge i_clk) begin
    if (i_clk_en && wr_ok && i_wr_sel < 5'(GPR_COUNT)) begin
      gpr_reg[i_wr_sel[3:0]] <= i_wr_data;
    end
  end

  // banked stack pointers; process pointers keep no defined reset value
  always_ff @(posedge i_clk) begin
    if (i_clk_en) begin
      if (i_vec_load) begin
        // bank 0 is the main stack in both configurations
        sp_reg[STK_MAIN_S] <= i_vec_sp;
      end else if (sp_move && !below) begin
        sp_reg[act_idx] <= cand;
      end else if (wr_ok) begin
        case (i_wr_sel)
          BSPL_SEL_SP: sp_reg[act_idx] <= i_wr_data;
          BSPL_SEL_SECURE_MAIN_STACK_POINTER: sp_reg[STK_MAIN_S] <= i_wr_data;
          BSPL_SEL_SECURE_PROCESS_STACK_POINTER: sp_reg[STK_PROC_S] <= i_wr_data;
          BSPL_SEL_NONSECURE_MAIN_STACK_POINTER: sp_reg[STK_MAIN_NS] <= i_wr_data;
          BSPL_SEL_NONSECURE_PROCESS_STACK_POINTER: sp_reg[STK_PROC_NS] <= i_wr_data;
          default: ;
        endcase
      end
    end
  end

  // banked limits, low bits forced to zero on write
  generate
    for (genvar k = 0; k < 4; k++) begin : g_lim
      always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
          lim_reg[k] <= LIMIT_RESET;
        end else if (i_clk_en && wr_ok && i_wr_sel == 5'(BSPL_SEL_MLIM_S) + 5'(k)) begin
          lim_reg[k] <= {i_wr_data[31:LIMIT_LSB], {LIMIT_LSB{1'b0}}};
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      link_register_reg <= SECURE_EXT ? STATUS_RESET : LINK_RESET_NOSEC;
    end else if (i_clk_en && wr_ok && i_wr_sel == BSPL_SEL_LINK) begin
      link_register_reg <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      program_counter_reg <= STATUS_RESET;
    end else if (i_clk_en) begin
      if (i_vec_load) begin
        program_counter_reg <= i_vec_pc;
      end else if (i_pc_upd) begin
        program_counter_reg <= i_pc_value;
      end else if (wr_ok && i_wr_sel == BSPL_SEL_PC) begin
        program_counter_reg <= i_wr_data;
      end
    end
  end

  // status: only application flags are writable; exception number follows the pipeline
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      status_reg <= STATUS_RESET;
    end else if (i_clk_en) begin
      if (i_vec_load) begin
        status_reg <= STATUS_RESET;
        status_reg[THUMB_BIT] <= i_vec_pc[0];
      end else begin
        status_reg[EXC_NUM_W-1:0] <= i_exc_num;
        if (wr_ok && i_wr_sel == BSPL_SEL_STATUS) begin
          // old exception number cleared first, else the two numbers would merge
          status_reg <= (status_reg & ~APP_FLAGS_MASK & ~EXC_NUM_MASK) | (i_wr_data & APP_FLAGS_MASK) |
                        {23'h000000, i_exc_num};
        end
      end
    end
  end

  // registered read port
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rd_data <= 32'h0000_0000;
      o_rd_denied <= 1'b0;
    end else if (i_clk_en) begin
      o_rd_denied <= i_rd_en && ((!i_privileged && needs_priv(i_rd_sel)) || sel_absent(i_rd_sel));
      if (!i_rd_en || (!i_privileged && needs_priv(i_rd_sel)) || sel_absent(i_rd_sel)) begin
        o_rd_data <= 32'h0000_0000;
      end else if (i_rd_sel < 5'(GPR_COUNT)) begin
        o_rd_data <= gpr_reg[i_rd_sel[3:0]];
      end else begin
        case (i_rd_sel)
          BSPL_SEL_SP: o_rd_data <= sp_reg[act_idx];
          BSPL_SEL_LINK: o_rd_data <= link_register_reg;
          BSPL_SEL_PC: o_rd_data <= program_counter_reg;
          BSPL_SEL_STATUS: o_rd_data <= status_reg & ~EXEC_STATE_MASK &
                                        ~(32'h1 << THUMB_BIT);
          BSPL_SEL_SECURE_MAIN_STACK_POINTER: o_rd_data <= sp_reg[STK_MAIN_S];
          BSPL_SEL_SECURE_PROCESS_STACK_POINTER: o_rd_data <= sp_reg[STK_PROC_S];
          BSPL_SEL_NONSECURE_MAIN_STACK_POINTER: o_rd_data <= sp_reg[STK_MAIN_NS];
          BSPL_SEL_NONSECURE_PROCESS_STACK_POINTER: o_rd_data <= sp_reg[STK_PROC_NS];
          BSPL_SEL_MLIM_S: o_rd_data <= lim_reg[STK_MAIN_S];
          BSPL_SEL_PLIM_S: o_rd_data <= lim_reg[STK_PROC_S];
          BSPL_SEL_MLIM_NS: o_rd_data <= lim_reg[STK_MAIN_NS];
          BSPL_SEL_PLIM_NS: o_rd_data <= lim_reg[STK_PROC_NS];
          default: o_rd_data <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_wr_denied <= 1'b0;
      o_limit_violation <= 1'b0;
      o_active_sp <= 32'h0000_0000;
      o_push_addr <= 32'h0000_0000;
      o_program_counter <= 32'h0000_0000;
      o_combined_status_word <= STATUS_RESET;
    end else if (i_clk_en) begin
      o_wr_denied <= i_wr_en && !wr_ok;
      o_limit_violation <= sp_move && !i_vec_load && below;
      o_active_sp <= sp_reg[act_idx];
      o_push_addr <= cand;
      o_program_counter <= program_counter_reg;
      o_combined_status_word <= status_reg;
    end
  end
endmodule : bspl_regs
`default_nettype wire

// ==== sim/bspl_regs_properties.sv ====
// Purpose: port checks for bspl_regs
// Assumes: checks pause while the clock enable is low
// Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module bspl_regs_properties (
  // clock, enable and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // requests
  input wire logic i_vec_load,
  input wire logic i_rd_en,
  input wire logic i_privileged,
  input wire logic i_push,
  input wire logic [4:0] i_rd_sel,
  input wire logic [31:0] i_vec_pc,
  // answers
  input wire logic o_rd_denied,
  input wire logic o_limit_violation,
  input wire logic [31:0] o_rd_data,
  input wire logic [31:0] o_active_sp,
  input wire logic [31:0] o_push_addr,
  input wire logic [31:0] o_program_counter,
  input wire logic [31:0] o_combined_status_word
);
  import bspl_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  // a frozen cycle holds every output, so the one-cycle checks pause with it
  default disable iff (!i_reset_n || !i_clk_en);
  wire logic lim_sel = (i_rd_sel >= 5'h15) && (i_rd_sel <= 5'h18);
  sequence s_push_ok;
    i_push ##1 !o_limit_violation;
  endsequence
  lim_low_zero_a: assert property (i_rd_en && lim_sel |=> o_rd_data[2:0] == 3'h0)
    else $error("limit low bits set");
  push_addr_a: assert property (i_push && !i_vec_load |=> o_push_addr == o_active_sp - PUSH_STEP)
    else $error("push address wrong");
  push_move_a: assert property (s_push_ok |=> o_active_sp == $past(o_push_addr))
    else $error("push did not move pointer");
  viol_keep_a: assert property (o_limit_violation |=> o_active_sp == $past(o_active_sp))
    else $error("pointer moved on violation");
  rd_deny_a: assert property (i_rd_en && lim_sel && !i_privileged |=> o_rd_denied && o_rd_data == 32'h0)
    else $error("limit read not refused");
  gpr_open_a: assert property (i_rd_en && i_rd_sel < 5'h0D |=> !o_rd_denied)
    else $error("data register refused");
  exec_hide_a: assert property (i_rd_en && i_rd_sel == 5'h10 |=> (o_rd_data & EXEC_STATE_MASK) == 32'h0)
    else $error("state bits visible");
  vec_pc_a: assert property (i_vec_load |-> ##2 o_program_counter == $past(i_vec_pc, 2)
    && o_combined_status_word[THUMB_BIT] == o_program_counter[0]) else $error("vector load wrong");
endmodule : bspl_regs_properties
bind bspl_regs bspl_regs_properties u_chk (.*);
`default_nettype wire

// ==== sim/bspl_pipe_model.sv ====
// Purpose: pipeline model driving register and stack ports
// Assumes: one request per call, held whole cycles
// Notes: released data shows the inverse so stale values never match
`timescale 1ns/1ps
`default_nettype none
module bspl_pipe_model (
  // clock and read answer
  input wire logic i_clk,
  input wire logic [31:0] i_rd_data,
  // requests
  output logic o_wr_en, o_rd_en, o_sp_upd, o_push,
  output logic [4:0] o_wr_sel, o_rd_sel,
  output logic [31:0] o_wr_data, o_sp_value
);
  initial begin
    {o_wr_en, o_rd_en, o_sp_upd, o_push} = 4'h0;
    {o_wr_sel, o_rd_sel, o_wr_data, o_sp_value} = '0;
  end
  task automatic wr(input logic [4:0] s, input logic [31:0] v);
    @(posedge i_clk) #1;
    {o_wr_en, o_wr_sel, o_wr_data} = {1'b1, s, v};
    @(posedge i_clk) #1;
    {o_wr_en, o_wr_data} = {1'b0, ~v};
  endtask : wr
  task automatic rd(input logic [4:0] s, output logic [31:0] v);
    @(posedge i_clk) #1;
    {o_rd_en, o_rd_sel} = {1'b1, s};
    @(posedge i_clk) #1;
    o_rd_en = 1'b0;
    v = i_rd_data;
  endtask : rd
  // back-to-back pushes come from holding the strobe n cycles
  task automatic mv(input logic p, input logic [31:0] v, input int n);
    @(posedge i_clk) #1;
    {o_push, o_sp_upd, o_sp_value} = {p, !p, v};
    repeat (n) @(posedge i_clk);
    #1;
    {o_push, o_sp_upd, o_sp_value} = {2'h0, ~v};
  endtask : mv
endmodule : bspl_pipe_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for bspl_regs
// Assumes: pc update unused; clock enable dropped once to check the freeze
// Notes: limit set so direct pointer updates reach the boundary; pushes stay above it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bspl_pkg::*;
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_clk_en = 1'b1, i_vec_load = 1'b0, i_pc_upd = 1'b0;
  logic i_handler_mode = 1'b0, i_secure = 1'b1, i_privileged = 1'b1;
  logic i_stack_select_bit_s = 1'b0, i_stack_select_bit_ns = 1'b0;
  logic [31:0] i_vec_sp = '0, i_vec_pc = '0, i_pc_value = '0, d;
  logic [EXC_NUM_W-1:0] i_exc_num = '0;
  logic i_wr_en, i_rd_en, i_sp_upd, i_push, o_rd_denied, o_wr_denied, o_limit_violation;
  logic [4:0] i_wr_sel, i_rd_sel;
  logic [31:0] i_wr_data, i_sp_value, o_rd_data, o_active_sp, o_push_addr, o_program_counter;
  logic [31:0] o_combined_status_word;
  logic [31:0] sp_bank [4] = '{32'h2000, 32'h4000, 32'h3000, 32'h5000};
  // answers of the second copy, built without the security extension
  logic n_rd_denied, n_wr_denied;
  logic [31:0] n_active_sp;
  int err_total = 0, num_checks = 0;
  always #12.5 i_clk = ~i_clk;
  bspl_pipe_model u_pipe (.i_clk(i_clk), .i_rd_data(o_rd_data), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
    .o_sp_upd(i_sp_upd), .o_push(i_push), .o_wr_sel(i_wr_sel), .o_rd_sel(i_rd_sel),
    .o_wr_data(i_wr_data), .o_sp_value(i_sp_value));
  bspl_regs u_dut (.*);
  bspl_regs #(.SECURE_EXT(1'h0)) u_dut_nosec (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_vec_load(i_vec_load), .i_vec_sp(i_vec_sp), .i_vec_pc(i_vec_pc), .i_handler_mode(i_handler_mode),
    .i_secure(i_secure), .i_privileged(i_privileged), .i_stack_select_bit_s(i_stack_select_bit_s),
    .i_stack_select_bit_ns(i_stack_select_bit_ns), .i_wr_en(i_wr_en), .i_wr_sel(i_wr_sel), .i_wr_data(i_wr_data),
    .i_rd_en(i_rd_en), .i_rd_sel(i_rd_sel), .i_sp_upd(i_sp_upd), .i_sp_value(i_sp_value), .i_push(i_push),
    .i_pc_upd(i_pc_upd), .i_pc_value(i_pc_value), .i_exc_num(i_exc_num), .o_rd_data(),
    .o_rd_denied(n_rd_denied), .o_wr_denied(n_wr_denied), .o_active_sp(n_active_sp), .o_push_addr(),
    .o_limit_violation(), .o_program_counter(), .o_combined_status_word());
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step
  task automatic rdc(input logic [4:0] s, input logic [31:0] e, input logic den);
    u_pipe.rd(s, d);
    chk("rd_data", e, d);
    chk("rd_denied", {31'h0, den}, {31'h0, o_rd_denied});
  endtask : rdc
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    step(16);
    i_reset_n = 1'b1;
    {i_vec_load, i_vec_sp, i_vec_pc} = {1'b1, 32'h2000, 32'h0000_0101};
    step(1);
    i_vec_load = 1'b0;
    step(1);
    chk("pc", 32'h101, o_program_counter);
    chk("status", 32'h0100_0000, o_combined_status_word);
    u_pipe.wr(5'h13, 32'h3000);
    chk("nosec_wr_denied", 32'h1, {31'h0, n_wr_denied});
    u_pipe.wr(5'h12, 32'h4000);
    u_pipe.wr(5'h14, 32'h5000);
    for (int i = 0; i < 8; i++) begin
      {i_secure, i_handler_mode, i_stack_select_bit_s} = i[2:0];
      i_stack_select_bit_ns = i[0];
      step(2);
      chk("active_sp", sp_bank[{~i[2], ~i[1] & i[0]}], o_active_sp);
      chk("nosec_active_sp", sp_bank[{1'h0, ~i[1] & i[0]}], n_active_sp);
    end
    {i_handler_mode, i_stack_select_bit_s, i_stack_select_bit_ns} = 3'h0;
    for (int i = 0; i < 4; i++) begin
      rdc(5'h15 + i[4:0], LIMIT_RESET, 1'b0);
      chk("nosec_rd_denied", {31'h0, i[1]}, {31'h0, n_rd_denied});
    end
    for (int i = 0; i < 4; i++) u_pipe.wr(5'h15 + i[4:0], 32'h0000_1007);
    for (int i = 0; i < 4; i++) rdc(5'h15 + i[4:0], 32'h1000, 1'b0);
    u_pipe.wr(5'h05, 32'hA5A5_5A5A);
    i_privileged = 1'b0;
    rdc(5'h05, 32'hA5A5_5A5A, 1'b0);
    rdc(5'h15, 32'h0, 1'b1);
    u_pipe.wr(5'h15, 32'h0000_8000);
    chk("wr_denied", 32'h1, {31'h0, o_wr_denied});
    i_privileged = 1'b1;
    rdc(5'h15, 32'h1000, 1'b0);
    u_pipe.mv(1'b1, 32'h0, 2);
    chk("push_addr", 32'h1FF8, o_push_addr);
    u_pipe.mv(1'b0, 32'h0FF8, 1);
    chk("violation", 32'h1, {31'h0, o_limit_violation});
    step(1);
    chk("sp_kept", 32'h1FF8, o_active_sp);
    u_pipe.mv(1'b0, 32'h1000, 1);
    chk("no_violation", 32'h0, {31'h0, o_limit_violation});
    step(1);
    chk("sp_at_limit", 32'h1000, o_active_sp);
    // with the enable low neither the write nor the pointer move may land
    i_clk_en = 1'b0;
    u_pipe.wr(5'h05, 32'h1234_5678);
    u_pipe.mv(1'b0, 32'h1800, 1);
    i_clk_en = 1'b1;
    step(1);
    chk("frozen_sp", 32'h1000, o_active_sp);
    rdc(5'h05, 32'hA5A5_5A5A, 1'b0);
    i_exc_num = 9'h003;
    u_pipe.wr(5'h10, 32'hFFFF_FFFF);
    rdc(5'h10, 32'hF80F_0003, 1'b0);
    i_reset_n = 1'b0;
    step(2);
    i_reset_n = 1'b1;
    rdc(5'h16, LIMIT_RESET, 1'b0);
    close_out();
  end
  initial begin
    repeat (4000) @(posedge i_clk);
    err_total++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
